// ===== verilog/brad_decoder.sv
// Per-master first-level address decoder with boot select and remap aliasing at address zero.
// Notes on behaviour
// RL1: Top four address bits pick one of sixteen 256-Mbyte banks.
// RL2: Banks 1 to 7 go to the external bus, each with its chip select.
// RL3: Bank 0 goes to internal memories through a 1-Mbyte second decode.
// RL4: Bank 15 goes to the peripheral bridge.
// RL5: Unused areas reach no slave and abort the master.
// RL6: Every master has its own decoder instance with the same map.
// RL7: For processor masters address zero maps to ROM, external boot or low SRAM.
// RL8: With remap set, the first SRAM bank appears at address zero.
// RL9: Without remap, the captured boot-select level picks ROM or external.
// RL10: The boot alias spans address zero up to, but not including, the 1-Mbyte boundary.
// RL11: Captured boot-select high aliases the embedded ROM.
// RL12: Captured boot-select low aliases external chip select zero.
// RL13: Unaffected memories stay at their normal base addresses always.
// RL14: After reset fetching at zero hits the selected boot memory, except in the first enabled cycle after release, which goes to ROM.
// RL15: System controller registers decode in the top 16 Kbytes.
// RL16: Meaningless master-to-slave paths are unconnected and abort.
// RL17: The boot-select pin is captured only once, in the first enabled cycle after reset release.
// RL18: Remap is cleared by system reset.
// RL19: An abort is returned as an AHB error response.
`timescale 1ns/1ns

module brad_decoder #(
	parameter int unsigned MASTER_ID = 0
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 clkEn,
	input  wire logic                 bootMemorySelect,
	input  wire logic                 remapSet,
	input  wire logic                 remapClear,
	input  wire brad_pkg::brad_req_s  req,
	output brad_pkg::brad_route_s     route,
	output logic                      hreadyErr,
	output logic [1:0]                hresp,
	output logic                      remapActive
);

	// ------------------------------------------------------------------
	// Path permissions
	// ------------------------------------------------------------------
	// Processor masters are 0 and 1; DMA is 2, USB host 3, image 4, MAC 5.
	localparam logic IS_CPU    = (MASTER_ID < 2);
	localparam logic ROM_OK    = (MASTER_ID < 4);
	localparam logic UHP_OK    = (MASTER_ID < 2);
	localparam logic PERIPH_OK = (MASTER_ID < 4);

	function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		inRange = (a >= lo) && (a <= hi);
	endfunction : inRange

	// ------------------------------------------------------------------
	// Boot select capture and remap
	// ------------------------------------------------------------------
	logic bootSync1;
	logic bootSync2;
	logic bootCaptured_reg;
	logic bootArmed_reg;
	logic remap_reg;

	// The synchroniser has no reset so that it keeps following the pin while reset is low.
	always_ff @(posedge clk) begin
		if (clkEn) begin
			bootSync1 <= bootMemorySelect;
			bootSync2 <= bootSync1;
		end
	end

	// Captured once after reset release; later pin changes are ignored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bootCaptured_reg <= brad_pkg::BOOT_SEL_RESET;
			bootArmed_reg    <= 1'b1;
		end else if (clkEn && bootArmed_reg) begin // RL17
			bootCaptured_reg <= bootSync2;
			bootArmed_reg    <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remap_reg <= brad_pkg::REMAP_RESET; // RL18
		end else if (clkEn) begin
			if (remapSet) begin
				remap_reg <= 1'b1; // RL8
			end else if (remapClear) begin
				remap_reg <= 1'b0;
			end
		end
	end

	assign remapActive = remap_reg;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	brad_pkg::brad_route_s routeNext;
	logic [3:0]            bank;
	logic                  active;

	assign bank   = req.addr[brad_pkg::BANK_MSB:brad_pkg::BANK_LSB]; // RL1
	assign active = req.sel && req.trans[1];

	always_comb begin
		routeNext       = '0;
		routeNext.valid = active;
		routeNext.slave = brad_pkg::BRAD_SL_NONE;
		if (bank == brad_pkg::BANK_INTERNAL) begin // RL3
			if (IS_CPU && req.addr <= brad_pkg::BOOT_ALIAS_TOP) begin // RL7 RL10
				if (remap_reg) begin
					routeNext.slave = brad_pkg::BRAD_SL_LOW_SRAM; // RL8
				end else if (bootCaptured_reg) begin
					routeNext.slave = brad_pkg::BRAD_SL_ROM; // RL9 RL11 RL14
				end else begin
					routeNext.slave      = brad_pkg::BRAD_SL_EXT; // RL12
					routeNext.chipSel[0] = 1'b1;
				end
			end else if (ROM_OK && inRange(req.addr, brad_pkg::ROM_BASE,
				brad_pkg::ROM_TOP)) begin // RL13
				routeNext.slave = brad_pkg::BRAD_SL_ROM;
			end else if (inRange(req.addr, brad_pkg::LOW_SRAM_BASE, brad_pkg::LOW_SRAM_TOP)) begin
				routeNext.slave = brad_pkg::BRAD_SL_LOW_SRAM;
			end else if (inRange(req.addr, brad_pkg::SRAM1_BASE, brad_pkg::SRAM1_TOP)) begin
				routeNext.slave = brad_pkg::BRAD_SL_SRAM1;
			end else if (UHP_OK && inRange(req.addr, brad_pkg::UHP_BASE,
				brad_pkg::UHP_TOP)) begin // RL16
				routeNext.slave = brad_pkg::BRAD_SL_UHP;
			end
		end else if (bank >= brad_pkg::BANK_EXT_FIRST && bank <= brad_pkg::BANK_EXT_LAST) begin
			routeNext.slave       = brad_pkg::BRAD_SL_EXT; // RL2
			routeNext.chipSel[bank[2:0]] = 1'b1;
		end else if (bank == brad_pkg::BANK_PERIPH && PERIPH_OK) begin // RL4 RL16
			if (req.addr >= brad_pkg::SYSC_BASE) begin
				routeNext.slave = brad_pkg::BRAD_SL_SYSC; // RL15
			end else begin
				routeNext.slave = brad_pkg::BRAD_SL_PERIPH;
			end
		end
		if (routeNext.slave == brad_pkg::BRAD_SL_NONE) begin
			routeNext.chipSel = '0;
			routeNext.abort   = active; // RL5
		end
		if (!active) begin
			routeNext.slave   = brad_pkg::BRAD_SL_NONE;
			routeNext.chipSel = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			route <= '0;
		end else if (clkEn) begin
			route <= routeNext; // RL6
		end
	end

	// ------------------------------------------------------------------
	// Two-cycle AHB error response
	// ------------------------------------------------------------------
	logic errSecond_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			errSecond_reg <= 1'b0;
		end else if (clkEn) begin
			errSecond_reg <= route.abort && !errSecond_reg;
		end
	end

	// First error cycle holds HREADY low, second raises it; HRESP stays ERROR.
	assign hresp     = (route.abort || errSecond_reg) ? 2'h1 : 2'h0; // RL19
	assign hreadyErr = !(route.abort && !errSecond_reg);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_ext_cs;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && bank == 4'h3 |=> route.chipSel == 8'h08
			&& route.slave == brad_pkg::BRAD_SL_EXT;
	endproperty
	a_ext_cs: assert property (p_ext_cs) else $error("bank 3 not on chip select 3"); // RL2

	property p_unused_abort;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && bank == 4'h9 |=> route.abort && hresp == 2'h1
			&& route.slave == brad_pkg::BRAD_SL_NONE;
	endproperty
	a_unused_abort: assert property (p_unused_abort) else $error("unused bank not aborted"); // RL5

	property p_periph;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && bank == 4'hF && req.addr < brad_pkg::SYSC_BASE && PERIPH_OK
			|=> route.slave == brad_pkg::BRAD_SL_PERIPH;
	endproperty
	a_periph: assert property (p_periph) else $error("bank 15 not on peripheral bridge"); // RL4

	property p_remap_zero;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && remap_reg && IS_CPU && req.addr == 32'h0000_0000
			|=> route.slave == brad_pkg::BRAD_SL_LOW_SRAM;
	endproperty
	a_remap_zero: assert property (p_remap_zero) else $error("remap not at zero"); // RL8

	property p_boot_rom;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && !remap_reg && bootCaptured_reg && IS_CPU
			&& req.addr == brad_pkg::BOOT_ALIAS_TOP |=> route.slave == brad_pkg::BRAD_SL_ROM;
	endproperty
	a_boot_rom: assert property (p_boot_rom) else $error("boot alias not ROM"); // RL11

	property p_boot_ext;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && !remap_reg && !bootCaptured_reg && IS_CPU && bank == 4'h0
			&& req.addr <= brad_pkg::BOOT_ALIAS_TOP |=> route.chipSel == 8'h01;
	endproperty
	a_boot_ext: assert property (p_boot_ext) else $error("boot alias not chip select 0"); // RL12

	property p_capture_hold;
		@(posedge clk) disable iff (!rst_n)
		!bootArmed_reg |=> $stable(bootCaptured_reg);
	endproperty
	a_capture_hold: assert property (p_capture_hold) else $error("boot select resampled"); // RL17

	property p_sram1_fixed;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && inRange(req.addr, brad_pkg::SRAM1_BASE, brad_pkg::SRAM1_TOP)
			|=> route.slave == brad_pkg::BRAD_SL_SRAM1;
	endproperty
	a_sram1_fixed: assert property (p_sram1_fixed) else $error("SRAM1 moved"); // RL13

	property p_err_two;
		@(posedge clk) disable iff (!rst_n)
		clkEn && routeNext.abort && hreadyErr ##1 clkEn |-> !hreadyErr ##1 hreadyErr
			&& hresp == 2'h1;
	endproperty
	a_err_two: assert property (p_err_two) else $error("error response not two cycles"); // RL19

	property p_sysc;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && bank == 4'hF && req.addr >= brad_pkg::SYSC_BASE && PERIPH_OK
			|=> route.slave == brad_pkg::BRAD_SL_SYSC;
	endproperty
	a_sysc: assert property (p_sysc) else $error("system controller not decoded"); // RL15

	property p_alias_cpu_only;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && !IS_CPU && req.addr <= brad_pkg::BOOT_ALIAS_TOP |=> route.abort;
	endproperty
	a_alias_cpu_only: assert property (p_alias_cpu_only) else $error("alias open to non-CPU"); // RL7

	property p_periph_forbidden;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && !PERIPH_OK && bank == 4'hF |=> route.abort;
	endproperty
	a_periph_forbidden: assert property (p_periph_forbidden) else $error("forbidden path open"); // RL16

	property p_chipsel_onehot;
		@(posedge clk) disable iff (!rst_n)
		$onehot0(route.chipSel);
	endproperty
	a_chipsel_onehot: assert property (p_chipsel_onehot) else $error("chip selects not one-hot"); // RL2

	property p_abort_no_slave;
		@(posedge clk) disable iff (!rst_n)
		route.abort |-> route.slave == brad_pkg::BRAD_SL_NONE && route.chipSel == 8'h00;
	endproperty
	a_abort_no_slave: assert property (p_abort_no_slave) else $error("aborted access reached a slave"); // RL5

	property p_idle_quiet;
		@(posedge clk) disable iff (!rst_n)
		clkEn && !active
			|=> !route.valid && !route.abort && route.slave == brad_pkg::BRAD_SL_NONE;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle cycle routed"); // RL5

	property p_okay;
		@(posedge clk) disable iff (!rst_n)
		!route.abort && !errSecond_reg |-> hresp == 2'h0 && hreadyErr;
	endproperty
	a_okay: assert property (p_okay) else $error("error response without abort"); // RL19

	property p_remap_set;
		@(posedge clk) disable iff (!rst_n)
		clkEn && remapSet |=> remap_reg;
	endproperty
	a_remap_set: assert property (p_remap_set) else $error("remap not set"); // RL8

	property p_low_sram_fixed;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && inRange(req.addr, brad_pkg::LOW_SRAM_BASE, brad_pkg::LOW_SRAM_TOP)
			|=> route.slave == brad_pkg::BRAD_SL_LOW_SRAM;
	endproperty
	a_low_sram_fixed: assert property (p_low_sram_fixed) else $error("low SRAM moved"); // RL13

	property p_ext_top;
		@(posedge clk) disable iff (!rst_n)
		clkEn && active && bank == 4'h7 |=> route.chipSel == 8'h80;
	endproperty
	a_ext_top: assert property (p_ext_top) else $error("bank 7 not on chip select 7"); // RL2

	c_remap: cover property (@(posedge clk) disable iff (!rst_n) $rose(remap_reg));
	c_abort: cover property (@(posedge clk) disable iff (!rst_n) route.abort);
	c_sysc: cover property (@(posedge clk) disable iff (!rst_n)
		route.slave == brad_pkg::BRAD_SL_SYSC);
	c_boot_ext: cover property (@(posedge clk) disable iff (!rst_n)
		route.slave == brad_pkg::BRAD_SL_EXT && route.chipSel[0]);
	c_err_pair: cover property (@(posedge clk) disable iff (!rst_n)
		!hreadyErr ##1 hreadyErr && hresp == 2'h1);

endmodule : brad_decoder

// ===== verilog/brad_pkg.sv
// Package with address map constants and carrier types for the boot remap address decoder.
package brad_pkg;

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam int          ADDR_W         = 32;
	localparam int          BANK_MSB       = 31;
	localparam int          BANK_LSB       = 28;
	localparam logic [3:0]  BANK_INTERNAL  = 4'h0;
	localparam logic [3:0]  BANK_EXT_FIRST = 4'h1;
	localparam logic [3:0]  BANK_EXT_LAST  = 4'h7;
	localparam logic [3:0]  BANK_PERIPH    = 4'hF;
	localparam logic [31:0] BOOT_ALIAS_TOP = 32'h000F_FFFF;
	localparam logic [31:0] ROM_BASE       = 32'h0010_0000;
	localparam logic [31:0] ROM_TOP        = 32'h0010_7FFF;
	localparam logic [31:0] LOW_SRAM_BASE  = 32'h0020_0000;
	localparam logic [31:0] LOW_SRAM_TOP   = 32'h0020_0FFF;
	localparam logic [31:0] SRAM1_BASE     = 32'h0030_0000;
	localparam logic [31:0] SRAM1_TOP      = 32'h0030_0FFF;
	localparam logic [31:0] UHP_BASE       = 32'h0050_0000;
	localparam logic [31:0] UHP_TOP        = 32'h005F_FFFF;
	localparam logic [31:0] SYSC_BASE      = 32'hFFFF_C000;
	localparam logic        REMAP_RESET    = 1'b0;
	localparam logic        BOOT_SEL_RESET = 1'b1;

	// ------------------------------------------------------------------
	// Slave targets
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		BRAD_SL_NONE,
		BRAD_SL_ROM,
		BRAD_SL_LOW_SRAM,
		BRAD_SL_SRAM1,
		BRAD_SL_UHP,
		BRAD_SL_EXT,
		BRAD_SL_PERIPH,
		BRAD_SL_SYSC
	} brad_slave_e;

	// Master request as seen on the AHB address phase.
	typedef struct packed {
		logic        sel;
		logic [1:0]  trans;
		logic [31:0] addr;
	} brad_req_s;

	// Decoded route, registered towards the slaves.
	typedef struct packed {
		logic        valid;
		brad_slave_e slave;
		logic [7:0]  chipSel;
		logic        abort;
	} brad_route_s;

endpackage : brad_pkg

// ===== testbench/brad_master.sv
// Bus master model that issues single address phases and remap pulses.
`timescale 1ns/1ns
module brad_master (
	input  wire logic           clk,
	output brad_pkg::brad_req_s req,
	output logic                remapSet,
	output logic                remapClear
);
	initial begin
		req        = '0;
		remapSet   = 1'b0;
		remapClear = 1'b0;
	end

	// Once released, the bus shows the inverted address so no stale value can match.
	task automatic issue(input logic [31:0] a);
		@(posedge clk);
		req <= '{sel: 1'b1, trans: 2'b10, addr: a};
		@(posedge clk);
		req <= '{sel: 1'b0, trans: 2'b00, addr: ~a};
		#1;
	endtask : issue

	task automatic pulse(input logic set);
		@(posedge clk);
		remapSet   <= set;
		remapClear <= !set;
		@(posedge clk);
		remapSet   <= 1'b0;
		remapClear <= 1'b0;
		#1;
	endtask : pulse
endmodule : brad_master

// ===== testbench/brad_decoder_test.sv
// Self-checking bench for the boot remap address decoder.
`timescale 1ns/1ns
module brad_decoder_test;
	localparam brad_pkg::brad_slave_e NO  = brad_pkg::BRAD_SL_NONE;
	localparam brad_pkg::brad_slave_e ROM = brad_pkg::BRAD_SL_ROM;
	localparam brad_pkg::brad_slave_e EXT = brad_pkg::BRAD_SL_EXT;
	localparam brad_pkg::brad_slave_e SR0 = brad_pkg::BRAD_SL_LOW_SRAM;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  clkEn = 1'b1;
	logic                  bootSel = 1'b1;
	logic                  remapSet;
	logic                  remapClear;
	logic                  hreadyErr;
	logic                  remapActive;
	logic [1:0]            hresp;
	brad_pkg::brad_req_s   req;
	brad_pkg::brad_route_s route;
	brad_pkg::brad_route_s route5;
	int                    errorCnt = 0;
	int                    checked = 0;

	always #5 clk = ~clk;

	brad_master master (.clk(clk), .req(req), .remapSet(remapSet), .remapClear(remapClear));
	brad_decoder DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .bootMemorySelect(bootSel),
		.remapSet(remapSet), .remapClear(remapClear), .req(req), .route(route),
		.hreadyErr(hreadyErr), .hresp(hresp), .remapActive(remapActive));
	brad_decoder #(.MASTER_ID(5)) DUT5 (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
		.bootMemorySelect(bootSel), .remapSet(remapSet), .remapClear(remapClear), .req(req),
		.route(route5), .hreadyErr(), .hresp(), .remapActive());

	// ------------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------------
	task automatic wrapUp;
		$display("errors %0d, comparisons %0d", errorCnt, checked);
		if (errorCnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrapUp

	task automatic chkBit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chkBit

	task automatic chkRoute(input brad_pkg::brad_route_s g, input brad_pkg::brad_slave_e s,
		input logic [7:0] cs);
		chkBit(g === brad_pkg::brad_route_s'{1'b1, s, cs, s == NO}, 1'b1, "route");
	endtask : chkRoute

	// Issues one request and checks the route, the error pair when it aborts, and the idle cycle after it.
	task automatic go(input logic [31:0] a, input brad_pkg::brad_slave_e s,
		input logic [7:0] cs = 8'h00);
		master.issue(a);
		chkRoute(route, s, cs);
		if (s == NO) begin
			chkBit(hreadyErr, 1'b0, "ready in first error cycle");
			chkBit(hresp === 2'h1, 1'b1, "error response");
			@(posedge clk);
			#1;
			chkBit(hreadyErr, 1'b1, "ready in second error cycle");
			chkBit(hresp === 2'h1, 1'b1, "error response held");
		end
		@(posedge clk);
		#1;
		chkBit(hresp === 2'h0, 1'b1, "okay after transfer");
	endtask : go

	task automatic resetDut(input logic b);
		@(posedge clk);
		rst_n   <= 1'b0;
		bootSel <= b;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask : resetDut

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic scBanks;
		for (int b = 1; b < 15; b++) begin
			if (b < 8)
				go({4'(b), 28'h000_0004}, EXT, 8'h01 << b);
			else
				go({4'(b), 28'h800_0000}, NO);
		end
	endtask : scBanks

	task automatic scInternal;
		go(32'h0, ROM);
		go(brad_pkg::BOOT_ALIAS_TOP, ROM);
		go(brad_pkg::ROM_TOP, ROM);
		go(brad_pkg::ROM_TOP + 1, NO);
		go(brad_pkg::LOW_SRAM_BASE, SR0);
		go(brad_pkg::SRAM1_TOP, brad_pkg::BRAD_SL_SRAM1);
		go(brad_pkg::UHP_BASE, brad_pkg::BRAD_SL_UHP);
		go(32'h0FFF_FFFC, NO);
		go(32'hF000_0000, brad_pkg::BRAD_SL_PERIPH);
		go(brad_pkg::SYSC_BASE - 1, brad_pkg::BRAD_SL_PERIPH);
		go(32'hFFFF_FFFF, brad_pkg::BRAD_SL_SYSC);
	endtask : scInternal

	task automatic scRemap;
		@(posedge clk);
		bootSel <= 1'b0;
		go(32'h0, ROM);
		master.pulse(1'b1);
		chkBit(remapActive, 1'b1, "remap set");
		go(32'h0, SR0);
		go(brad_pkg::ROM_BASE, ROM);
		go(brad_pkg::LOW_SRAM_BASE, SR0);
		master.pulse(1'b0);
		chkBit(remapActive, 1'b0, "remap cleared");
		go(32'h0, ROM);
		master.pulse(1'b1);
		resetDut(1'b0);
		chkBit(remapActive, 1'b0, "remap after reset");
		go(32'h0, EXT, 8'h01);
		go(brad_pkg::ROM_BASE, ROM);
	endtask : scRemap

	// While the enable is low nothing moves, not even a remap pulse or a request.
	task automatic scFreeze;
		@(posedge clk);
		clkEn <= 1'b0;
		master.pulse(1'b1);
		chkBit(remapActive, 1'b0, "remap moved while frozen");
		master.issue(32'h3000_0000);
		chkBit(route === '0, 1'b1, "route moved while frozen");
		@(posedge clk);
		clkEn <= 1'b1;
	endtask : scFreeze

	// The last master decodes beside the processor one; forbidden paths abort there only.
	task automatic scPaths;
		logic [31:0] adr[5] = '{32'h0, brad_pkg::ROM_BASE, 32'hF000_0000,
			brad_pkg::LOW_SRAM_BASE, 32'h3000_0000};
		brad_pkg::brad_slave_e exp[5] = '{NO, NO, NO, SR0, EXT};
		for (int i = 0; i < 5; i++) begin
			master.issue(adr[i]);
			chkRoute(route5, exp[i], (i == 4) ? 8'h08 : 8'h00);
			repeat (3) @(posedge clk);
		end
	endtask : scPaths

	initial begin
		resetDut(1'b1);
		scBanks();
		scInternal();
		scPaths();
		scFreeze();
		scRemap();
		wrapUp();
	end

	initial begin
		#50000;
		errorCnt++;
		wrapUp();
	end
endmodule : brad_decoder_test
